// [rtl/sfp_pkg.sv]
// Package: opcodes, timing constants, states and carrier structs for the flash sequencer
package sfp_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE   = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE   = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A    = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B    = 8'hC7;
  localparam logic [7:0] OP_DEEP_SLEEP      = 8'hB9;
  localparam logic [7:0] OP_WAKE_IDENTIFY   = 8'hAB;

  // Frame layout in serial clock edges
  localparam int unsigned OPCODE_BITS   = 8;
  localparam int unsigned ADDR_END_BITS = 32;
  localparam int unsigned QUAD_BYTE_CLK = 2;
  localparam int unsigned PAGE_BYTES    = 256;
  localparam int unsigned QUAD_EN_POS   = 9;

  // Region shifts for protect comparison
  localparam int unsigned SECTOR_SHIFT  = 12;
  localparam int unsigned BLK32_SHIFT   = 15;
  localparam int unsigned BLK64_SHIFT   = 16;
  localparam int unsigned PAGE_SHIFT    = 8;

  // Timing, clk 20 MHz
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned PAGE_TIME_US   = 700;
  localparam int unsigned ERASE_TIME_US  = 100;
  localparam int unsigned CHIP_TIME_US   = 2000;
  localparam int unsigned SLEEP_DLY_US   = 3;
  localparam int unsigned WAKE_DLY_US    = 3;
  localparam int unsigned SLEEP_DLY_CYC  = SLEEP_DLY_US * CLK_MHZ;
  localparam int unsigned WAKE_DLY_CYC   = WAKE_DLY_US * CLK_MHZ;
  localparam int unsigned LATCH_CLR_CYC  = 2;

  typedef enum logic [2:0] {
    SFP_OP_NONE, SFP_OP_PAGE, SFP_OP_SECT, SFP_OP_B32, SFP_OP_B64, SFP_OP_CHIP
  } sfp_op_t;

  typedef enum {SFP_ST_STANDBY, SFP_ST_BUSY, SFP_ST_SLEEP_WAIT, SFP_ST_SLEEP,
                SFP_ST_WAKE_WAIT} sfp_state_t;

  // Request to the array
  typedef struct packed {
    sfp_op_t     op;
    logic [23:0] addr;
    logic [8:0]  count;
  } sfp_req_t;

  // Protection setting
  typedef struct packed {
    logic [4:0] bp;
    logic       complement;
  } sfp_prot_t;

endpackage : sfp_pkg

// [rtl/sfp_seq.sv]
// Flash program, erase and deep-sleep command sequencer
`timescale 1ns/1ps
// What this block does
// - Quad page write runs only with quad mode enable, status bit 9, set.
// - Over 256 data bytes keeps only the last 256 in the page.
// - Fewer bytes program only addressed bytes, rest of page unchanged.
// - Page write runs only if select rises on a byte boundary.
// - Valid end starts timed cycle; busy flag high until it ends.
// - Write latch flag is cleared during every timed cycle.
// - Page write into a protected page is not run.
// - 20H with address is sector erase; any address in sector selects.
// - Sector or block erase runs only if select rises after bit 32.
// - 52H with address erases the containing 32KB block.
// - D8H with address erases the containing 64KB block.
// - Erase of a protected region is not run.
// - Chip erase 60H or C7H runs only if select rises after bit 8.
// - Chip erase needs low protect bits all 0 with cmp 0, or all 1 with cmp 1.
// - Deep-sleep B9H, then entry delay, then lowest power mode.
// - In deep sleep every command but wake-and-identify is ignored.
// - Deep-sleep command during a timed cycle is rejected.
// - Select high with no cycle running leaves device in standby.
// - Reset clears deep sleep and starts in standby.
// - Wake ABH, then wake delay, then commands accepted again.
module sfp_seq (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial link, sampled synchronously
  input  wire logic              cs_n,
  input  wire logic              sclk_rise,
  input  wire logic [3:0]        data_lane,
  // Status inputs
  input  wire logic [15:0]       status_word,
  input  wire sfp_pkg::sfp_prot_t prot,
  input  wire logic              array_done,
  // Status outputs
  output logic                   write_latch_flag,
  output logic                   write_busy_flag,
  output logic                   deep_sleep,
  output logic                   standby,
  // Array request and page buffer write port
  output sfp_pkg::sfp_req_t      req_q,
  output logic                   req_valid_q,
  output logic                   buf_we_q,
  output logic [7:0]             buf_idx_q,
  output logic [7:0]             buf_data_q
);

  sfp_pkg::sfp_state_t state_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [5:0]  bit_cnt_q;
  logic [8:0]  byte_cnt_q;
  logic [7:0]  data_sr_q;
  logic        quad_half_q;
  logic        cs_d1_q;
  logic [15:0] dly_q;
  logic        latch_q;
  logic [7:0]  page_off_q;
  logic        busy_q;

  wire cs_rise = cs_n && !cs_d1_q;
  wire cs_low  = !cs_n;

  // Region compare against protect setting; simple contiguous map from top
  function automatic logic region_protected(input logic [23:0] a, input int unsigned sh,
                                            input sfp_pkg::sfp_prot_t p);
    logic [7:0] top;
    logic [7:0] lim;
    logic       in_prot;
    top = a[23:16];
    lim = 8'h80 >> (3'd7 - p.bp[2:0]);
    in_prot = (p.bp[2:0] != 3'b000) && (top >= (8'h80 - lim));
    if (p.bp[2:0] == 3'b111) in_prot = 1'b1;
    region_protected = p.complement ? !in_prot : in_prot;
    if (sh == 0) region_protected = 1'b0;
  endfunction : region_protected

  function automatic sfp_pkg::sfp_op_t decode_op(input logic [7:0] op);
    case (op)
      sfp_pkg::OP_QUAD_PAGE_WRITE: decode_op = sfp_pkg::SFP_OP_PAGE;
      sfp_pkg::OP_SECTOR_ERASE:    decode_op = sfp_pkg::SFP_OP_SECT;
      sfp_pkg::OP_BLOCK32_ERASE:   decode_op = sfp_pkg::SFP_OP_B32;
      sfp_pkg::OP_BLOCK64_ERASE:   decode_op = sfp_pkg::SFP_OP_B64;
      sfp_pkg::OP_CHIP_ERASE_A,
      sfp_pkg::OP_CHIP_ERASE_B:    decode_op = sfp_pkg::SFP_OP_CHIP;
      default:                     decode_op = sfp_pkg::SFP_OP_NONE;
    endcase
  endfunction : decode_op

  // Select edge tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cs_d1_q <= 1'b1;
    else     cs_d1_q <= cs_n;
  end

  // Shift-in: opcode and address single lane, data on four lanes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q        <= 8'h00;
      addr_q      <= 24'h00_0000;
      bit_cnt_q   <= 6'h00;
      byte_cnt_q  <= 9'h000;
      page_off_q  <= 8'h00;
      data_sr_q   <= 8'h00;
      quad_half_q <= 1'b0;
      buf_we_q    <= 1'b0;
      buf_idx_q   <= 8'h00;
      buf_data_q  <= 8'h00;
    end else begin
      buf_we_q <= 1'b0;
      if (cs_n) begin
        bit_cnt_q   <= 6'h00;
        quad_half_q <= 1'b0;
        if (cs_rise) begin
          byte_cnt_q <= 9'h000;
          page_off_q <= 8'h00;
        end
      end else if (sclk_rise) begin
        if (bit_cnt_q < 6'(sfp_pkg::OPCODE_BITS)) begin
          op_q      <= {op_q[6:0], data_lane[0]};
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end else if (bit_cnt_q < 6'(sfp_pkg::ADDR_END_BITS)) begin
          addr_q    <= {addr_q[22:0], data_lane[0]};
          bit_cnt_q <= bit_cnt_q + 6'h01;
        end else begin
          if (bit_cnt_q == 6'(sfp_pkg::ADDR_END_BITS)) bit_cnt_q <= bit_cnt_q + 6'h01;
          data_sr_q   <= {data_sr_q[3:0], data_lane};
          quad_half_q <= !quad_half_q;
          if (quad_half_q) begin
            // Page wrap and overwrite keep only the last 256 bytes
            buf_we_q   <= 1'b1;
            buf_idx_q  <= addr_q[7:0] + page_off_q;
            buf_data_q <= {data_sr_q[3:0], data_lane};
            if (byte_cnt_q != 9'(sfp_pkg::PAGE_BYTES)) byte_cnt_q <= byte_cnt_q + 9'h001;
            // Offset keeps wrapping after the count saturates
            page_off_q <= page_off_q + 8'h01;
          end
        end
      end
    end
  end

  // Frame end classification
  logic frame_ok;
  sfp_pkg::sfp_op_t frame_op;
  always_comb begin
    frame_op = decode_op(op_q);
    frame_ok = 1'b0;
    case (frame_op)
      sfp_pkg::SFP_OP_PAGE:
        frame_ok = bit_cnt_q > 6'(sfp_pkg::ADDR_END_BITS) && !quad_half_q
                   && byte_cnt_q != 9'h000
                   && status_word[sfp_pkg::QUAD_EN_POS]
                   && !region_protected(addr_q, sfp_pkg::PAGE_SHIFT, prot);
      sfp_pkg::SFP_OP_SECT, sfp_pkg::SFP_OP_B32, sfp_pkg::SFP_OP_B64:
        frame_ok = bit_cnt_q == 6'(sfp_pkg::ADDR_END_BITS)
                   && !region_protected(addr_q, sfp_pkg::SECTOR_SHIFT, prot);
      sfp_pkg::SFP_OP_CHIP:
        frame_ok = bit_cnt_q == 6'(sfp_pkg::OPCODE_BITS)
                   && ((prot.bp[2:0] == 3'b000 && !prot.complement)
                    || (prot.bp[2:0] == 3'b111 && prot.complement));
      default: frame_ok = 1'b0;
    endcase
  end

  wire frame_end  = cs_low && cs_d1_q ? 1'b0 : (cs_n && !cs_d1_q);
  wire sleep_cmd  = op_q == sfp_pkg::OP_DEEP_SLEEP && bit_cnt_q == 6'(sfp_pkg::OPCODE_BITS);
  wire wake_cmd   = op_q == sfp_pkg::OP_WAKE_IDENTIFY && bit_cnt_q >= 6'(sfp_pkg::OPCODE_BITS);
  wire latch_cmd  = op_q == sfp_pkg::OP_WRITE_LATCH_SET && bit_cnt_q == 6'(sfp_pkg::OPCODE_BITS);

  // Main state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= sfp_pkg::SFP_ST_STANDBY;
      dly_q       <= 16'h0000;
      busy_q      <= 1'b0;
      req_valid_q <= 1'b0;
      req_q       <= '0;
    end else begin
      req_valid_q <= 1'b0;
      case (state_q)
        sfp_pkg::SFP_ST_STANDBY: begin
          if (frame_end) begin
            if (sleep_cmd) begin
              state_q <= sfp_pkg::SFP_ST_SLEEP_WAIT;
              dly_q   <= 16'(sfp_pkg::SLEEP_DLY_CYC);
            end else if (frame_ok && latch_q) begin
              state_q     <= sfp_pkg::SFP_ST_BUSY;
              busy_q      <= 1'b1;
              req_valid_q <= 1'b1;
              req_q       <= '{op: frame_op, addr: addr_q, count: byte_cnt_q};
              dly_q       <= 16'(sfp_pkg::LATCH_CLR_CYC);
            end
          end
        end
        sfp_pkg::SFP_ST_BUSY: begin
          // Sleep and new program opcodes are dropped here
          if (dly_q != 16'h0000) dly_q <= dly_q - 16'h0001;
          if (array_done && dly_q == 16'h0000) begin
            busy_q  <= 1'b0;
            state_q <= sfp_pkg::SFP_ST_STANDBY;
          end
        end
        sfp_pkg::SFP_ST_SLEEP_WAIT: begin
          if (dly_q == 16'h0000) state_q <= sfp_pkg::SFP_ST_SLEEP;
          else dly_q <= dly_q - 16'h0001;
        end
        sfp_pkg::SFP_ST_SLEEP: begin
          if (frame_end && wake_cmd) begin
            state_q <= sfp_pkg::SFP_ST_WAKE_WAIT;
            dly_q   <= 16'(sfp_pkg::WAKE_DLY_CYC);
          end
        end
        sfp_pkg::SFP_ST_WAKE_WAIT: begin
          if (dly_q == 16'h0000) state_q <= sfp_pkg::SFP_ST_STANDBY;
          else dly_q <= dly_q - 16'h0001;
        end
        default: state_q <= sfp_pkg::SFP_ST_STANDBY;
      endcase
    end
  end

  // Write latch: set by its command, cleared early in each timed cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) latch_q <= 1'b0;
    else if (state_q == sfp_pkg::SFP_ST_BUSY && dly_q == 16'h0001) latch_q <= 1'b0;
    else if (state_q == sfp_pkg::SFP_ST_STANDBY && frame_end && latch_cmd) latch_q <= 1'b1;
  end

  // Registered status outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_latch_flag <= 1'b0;
      write_busy_flag  <= 1'b0;
      deep_sleep       <= 1'b0;
      standby          <= 1'b1;
    end else begin
      write_latch_flag <= latch_q;
      write_busy_flag  <= busy_q;
      deep_sleep       <= state_q == sfp_pkg::SFP_ST_SLEEP;
      standby          <= state_q == sfp_pkg::SFP_ST_STANDBY && cs_n;
    end
  end

  busy_start_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q |-> ##1 write_busy_flag)
    else $error("busy flag not raised after cycle start");

  latch_clear_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_q) |-> !latch_q)
    else $error("write latch still set at cycle end");

  no_latch_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q |-> $past(latch_q))
    else $error("cycle started without write latch");

  busy_block_a: assert property (@(posedge clk) disable iff (rst)
    busy_q && !array_done |=> busy_q && !req_valid_q)
    else $error("new cycle accepted while busy");

  chip_prot_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q && req_q.op == sfp_pkg::SFP_OP_CHIP |->
      $past(prot.bp[2:0] == 3'b000 && !prot.complement
            || prot.bp[2:0] == 3'b111 && prot.complement))
    else $error("chip erase under protection");

  quad_en_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q && req_q.op == sfp_pkg::SFP_OP_PAGE |-> $past(status_word[sfp_pkg::QUAD_EN_POS]))
    else $error("quad write without quad enable");

  sleep_enter_a: assert property (@(posedge clk) disable iff (rst)
    state_q == sfp_pkg::SFP_ST_STANDBY && frame_end && sleep_cmd |=> !busy_q ##[1:80] deep_sleep)
    else $error("deep sleep not entered");

  sleep_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_q == sfp_pkg::SFP_ST_SLEEP |-> !req_valid_q)
    else $error("command run while in deep sleep");

  page_len_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q && req_q.op == sfp_pkg::SFP_OP_PAGE |->
      req_q.count != 9'h000 && req_q.count <= 9'(sfp_pkg::PAGE_BYTES))
    else $error("page write count out of range");

  erase_len_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q && req_q.op != sfp_pkg::SFP_OP_PAGE && req_q.op != sfp_pkg::SFP_OP_CHIP |->
      $past(bit_cnt_q) == 6'(sfp_pkg::ADDR_END_BITS))
    else $error("erase started off the address boundary");

  chip_len_a: assert property (@(posedge clk) disable iff (rst)
    req_valid_q && req_q.op == sfp_pkg::SFP_OP_CHIP |->
      $past(bit_cnt_q) == 6'(sfp_pkg::OPCODE_BITS))
    else $error("chip erase started off the opcode boundary");

  sleep_reject_a: assert property (@(posedge clk) disable iff (rst)
    state_q == sfp_pkg::SFP_ST_BUSY && frame_end && sleep_cmd |=>
      state_q != sfp_pkg::SFP_ST_SLEEP_WAIT && !deep_sleep)
    else $error("deep sleep taken during a timed cycle");

  idle_standby_a: assert property (@(posedge clk) disable iff (rst)
    state_q == sfp_pkg::SFP_ST_STANDBY && cs_n |=> standby)
    else $error("standby not shown while idle");

  wake_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_q == sfp_pkg::SFP_ST_WAKE_WAIT |=> !req_valid_q && !deep_sleep)
    else $error("command run during wake delay");

endmodule : sfp_seq

// [tb/sfp_host.sv]
// Serial host model: select, serial clock pulses and data lanes
`timescale 1ns/1ps
module sfp_host (
  // Clock
  input  wire logic clk,
  // Serial link
  output logic       cs_n,
  output logic       sclk_rise,
  output logic [3:0] data_lane
);
  initial begin
    cs_n      = 1'b1;
    sclk_rise = 1'b0;
    data_lane = 4'h0;
  end

  // Lanes are inverted after each edge so a stale value never looks valid
  task automatic edge_out(input logic [3:0] v);
    @(posedge clk);
    sclk_rise <= 1'b1;
    data_lane <= v;
    @(posedge clk);
    sclk_rise <= 1'b0;
    data_lane <= ~v;
  endtask : edge_out

  // Opcode and address MSB first on lane0, data bytes high nibble first
  task automatic frame(input logic [7:0] op, input int na, input logic [23:0] a,
                       input int nn, input logic [7:0] base);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) edge_out({3'h0, op[i]});
    for (int i = 23; i >= 24 - na; i--) edge_out({3'h0, a[i]});
    for (int i = 0; i < nn; i++) begin
      logic [7:0] b;
      b = base + 8'(i / 2);
      edge_out(i[0] ? b[3:0] : b[7:4]);
    end
    @(posedge clk);
    cs_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask : frame
endmodule : sfp_host

// [tb/sfp_seq_tb.sv]
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module sfp_seq_tb;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cs_n, sclk_rise;
  logic [3:0]         data_lane;
  logic [15:0]        status_word = 16'h0200;
  sfp_pkg::sfp_prot_t prot = 6'h00;
  logic               array_done = 1'b0;
  logic               latch, busy, deep_sleep, standby, req_valid_q, buf_we_q;
  sfp_pkg::sfp_req_t  req_q, last_req;
  logic [7:0]         buf_idx_q, buf_data_q, last_idx, last_data;
  int                 err_count, comparisons, req_cnt, we_cnt, busy_cnt;

  always #25 clk = ~clk;

  sfp_host sfp_host_inst (.clk(clk), .cs_n(cs_n), .sclk_rise(sclk_rise), .data_lane(data_lane));
  sfp_seq sfp_seq_inst (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk_rise(sclk_rise),
    .data_lane(data_lane), .status_word(status_word), .prot(prot), .array_done(array_done),
    .write_latch_flag(latch), .write_busy_flag(busy), .deep_sleep(deep_sleep),
    .standby(standby), .req_q(req_q), .req_valid_q(req_valid_q), .buf_we_q(buf_we_q),
    .buf_idx_q(buf_idx_q), .buf_data_q(buf_data_q));

  always @(posedge clk) begin
    if (req_valid_q === 1'b1) begin
      req_cnt++;
      last_req = req_q;
    end
    if (buf_we_q === 1'b1) begin
      we_cnt++;
      last_idx  = buf_idx_q;
      last_data = buf_data_q;
    end
  end

  // Array finishes a fixed span after busy rises, long enough to overlap a frame
  always @(posedge clk) begin
    busy_cnt   <= (busy === 1'b1) ? busy_cnt + 1 : 0;
    array_done <= (busy_cnt == 200);
  end

  task automatic idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clk);
    `CHK("idle", 1'b0, busy)
  endtask : idle

  // Latch set, then one command; go says whether a request must leave
  task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a,
                     input int nn, input bit go);
    int n0;
    n0 = req_cnt;
    sfp_host_inst.frame(sfp_pkg::OP_WRITE_LATCH_SET, 0, 24'h0, 0, 8'h00);
    sfp_host_inst.frame(op, na, a, nn, 8'h40);
    `CHK("request", go, req_cnt == n0 + 1)
    idle();
  endtask : cmd

  task automatic t_erase();
    sfp_host_inst.frame(sfp_pkg::OP_SECTOR_ERASE, 24, 24'h01_2345, 0, 8'h00);
    `CHK("no latch", 0, req_cnt)
    sfp_host_inst.frame(sfp_pkg::OP_WRITE_LATCH_SET, 0, 24'h0, 0, 8'h00);
    `CHK("latch", 1'b1, latch)
    sfp_host_inst.frame(sfp_pkg::OP_SECTOR_ERASE, 24, 24'h01_2345, 0, 8'h00);
    `CHK("busy", 1'b1, busy)
    `CHK("latch clr", 1'b0, latch)
    `CHK("sect op", sfp_pkg::SFP_OP_SECT, last_req.op)
    `CHK("sect", 12'h012, last_req.addr[23:12])
    idle();
    cmd(sfp_pkg::OP_BLOCK32_ERASE, 24, 24'h12_3456, 0, 1);
    `CHK("b32", 9'h024, last_req.addr[23:15])
    `CHK("b32 op", sfp_pkg::SFP_OP_B32, last_req.op)
    cmd(sfp_pkg::OP_BLOCK64_ERASE, 24, 24'h12_3456, 0, 1);
    `CHK("b64", 8'h12, last_req.addr[23:16])
    `CHK("b64 op", sfp_pkg::SFP_OP_B64, last_req.op)
    cmd(sfp_pkg::OP_CHIP_ERASE_A, 0, 24'h0, 0, 1);
    cmd(sfp_pkg::OP_CHIP_ERASE_B, 0, 24'h0, 0, 1);
    `CHK("chip op", sfp_pkg::SFP_OP_CHIP, last_req.op)
    cmd(sfp_pkg::OP_SECTOR_ERASE, 23, 24'h01_2345, 0, 0);
    cmd(sfp_pkg::OP_BLOCK64_ERASE, 24, 24'h01_2345, 1, 0);
    cmd(sfp_pkg::OP_CHIP_ERASE_A, 1, 24'h0, 0, 0);
  endtask : t_erase

  task automatic t_protect();
    @(posedge clk);
    prot <= 6'h02;
    cmd(sfp_pkg::OP_CHIP_ERASE_B, 0, 24'h0, 0, 0);
    cmd(sfp_pkg::OP_SECTOR_ERASE, 24, 24'hFF_F000, 0, 0);
    `CHK("latch kept", 1'b1, latch)
    cmd(sfp_pkg::OP_QUAD_PAGE_WRITE, 24, 24'hFF_FF00, 2, 0);
    @(posedge clk);
    prot <= 6'h0F;
    cmd(sfp_pkg::OP_CHIP_ERASE_A, 0, 24'h0, 0, 1);
    @(posedge clk);
    prot <= 6'h00;
  endtask : t_protect

  task automatic t_page();
    @(posedge clk);
    status_word <= 16'h0000;
    cmd(sfp_pkg::OP_QUAD_PAGE_WRITE, 24, 24'h00_0210, 6, 0);
    @(posedge clk);
    status_word <= 16'h0200;
    we_cnt = 0;
    cmd(sfp_pkg::OP_QUAD_PAGE_WRITE, 24, 24'h00_0210, 6, 1);
    `CHK("count", 9'h003, last_req.count)
    `CHK("writes", 3, we_cnt)
    `CHK("idx", 8'h12, last_idx)
    `CHK("data", 8'h42, last_data)
    cmd(sfp_pkg::OP_QUAD_PAGE_WRITE, 24, 24'h00_0210, 5, 0);
    cmd(sfp_pkg::OP_QUAD_PAGE_WRITE, 24, 24'h00_0300, 516, 1);
    `CHK("count", 9'h100, last_req.count)
    `CHK("idx", 8'h01, last_idx)
    `CHK("data", 8'h41, last_data)
  endtask : t_page

  task automatic t_sleep();
    cmd(sfp_pkg::OP_CHIP_ERASE_A, 0, 24'h0, 0, 1);
    sfp_host_inst.frame(sfp_pkg::OP_WRITE_LATCH_SET, 0, 24'h0, 0, 8'h00);
    sfp_host_inst.frame(sfp_pkg::OP_CHIP_ERASE_A, 0, 24'h0, 0, 8'h00);
    sfp_host_inst.frame(sfp_pkg::OP_DEEP_SLEEP, 0, 24'h0, 0, 8'h00);
    repeat (sfp_pkg::SLEEP_DLY_CYC + 5) @(posedge clk);
    `CHK("busy", 1'b1, busy)
    `CHK("sleep rej", 1'b0, deep_sleep)
    idle();
    sfp_host_inst.frame(sfp_pkg::OP_DEEP_SLEEP, 0, 24'h0, 0, 8'h00);
    `CHK("sleep wait", 1'b0, deep_sleep)
    repeat (sfp_pkg::SLEEP_DLY_CYC) @(posedge clk);
    `CHK("sleep", 1'b1, deep_sleep)
    `CHK("standby", 1'b0, standby)
    cmd(sfp_pkg::OP_SECTOR_ERASE, 24, 24'h00_1000, 0, 0);
    sfp_host_inst.frame(sfp_pkg::OP_WAKE_IDENTIFY, 0, 24'h0, 0, 8'h00);
    repeat (sfp_pkg::WAKE_DLY_CYC) @(posedge clk);
    `CHK("wake", 1'b0, deep_sleep)
    `CHK("standby", 1'b1, standby)
    cmd(sfp_pkg::OP_SECTOR_ERASE, 24, 24'h00_1000, 0, 1);
    sfp_host_inst.frame(sfp_pkg::OP_DEEP_SLEEP, 0, 24'h0, 0, 8'h00);
    repeat (sfp_pkg::SLEEP_DLY_CYC + 5) @(posedge clk);
    #1;
    `CHK("sleep again", 1'b1, deep_sleep)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("rst sleep", 1'b0, deep_sleep)
    `CHK("rst standby", 1'b1, standby)
  endtask : t_sleep

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Whole run is some five thousand cycles; this cuts a hang
  initial begin
    #3_000_000;
    err_count++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("standby", 1'b1, standby)
    `CHK("sleep", 1'b0, deep_sleep)
    `CHK("latch", 1'b0, latch)
    t_erase();
    t_protect();
    t_page();
    t_sleep();
    final_report();
  end
endmodule : sfp_seq_tb
